// ==== shared/fpg_defines.svh ====
`ifndef FPG_DEFINES_SVH
`define FPG_DEFINES_SVH

// Word indices of the registers; byte address is four times the index.
`define FPG_IDX_DIR       6'h00
`define FPG_IDX_VAL_SET   6'h01
`define FPG_IDX_VAL_CLR   6'h02
`define FPG_IDX_IEN_SET   6'h03
`define FPG_IDX_IEN_CLR   6'h04
`define FPG_IDX_POL       6'h05
`define FPG_IDX_SENS      6'h06
`define FPG_IDX_EDGE      6'h07
`define FPG_IDX_PEND      6'h08
`define FPG_IDX_PEND_SET  6'h09
`define FPG_IDX_CMASK     6'h0A
`define FPG_IDX_CFG       6'h0B

// Configuration register fields.
`define FPG_CFG_BUS16     0
`define FPG_CFG_SPI       1

// Reset values.
`define FPG_RST_16        16'h0000
`define FPG_RST_CFG       2'h0

// Pins owned by the upper data lines and eligible for select duty.
`define FPG_UPPER_MASK    16'hFF00
`define FPG_LOWER_MASK    16'h00FF

// Multiplier strap pins, caught at the first edge after reset release.
`define FPG_STRAP_LSB     0
`define FPG_STRAP_MSB     6

`endif

// ==== shared/fpg_pkg.sv ====
package fpg_pkg;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
    logic [31:0] hwdata;
  } fpg_ahb_req_type;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } fpg_ahb_rsp_type;

  typedef struct packed {
    logic [15:0] level;
    logic [15:0] oe_n;
  } fpg_pin_drive_type;

  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
  } fpg_cell_state_type;

endpackage : fpg_pkg

// ==== src/fpg_pin_cell.sv ====
`timescale 1ns/10ps
module fpg_pin_cell
  import fpg_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  input  wire logic sw_val_i,
  input  wire logic dir_i,
  input  wire logic gp_i,
  input  wire logic pol_i,
  input  wire logic sens_i,
  input  wire logic both_i,
  output logic      level_o,
  output logic      event_o
);

  fpg_cell_state_type q;
  fpg_cell_state_type d;
  logic               src;
  logic               act;

  // An output pin is its own software source, so the driven value is tested.
  assign src = dir_i ? sw_val_i : q.s2;
  assign act = pol_i ? src : ~src;
  assign level_o = q.s2;

  always_comb
  begin
    d = q;
    d.s1 = pin_i;
    d.s2 = q.s1;
    d.prev = act;
    if (!gp_i)
    begin
      event_o = 1'b0;
    end
    else if (!sens_i)
    begin
      event_o = act;
    end
    else if (both_i)
    begin
      event_o = act ^ q.prev;
    end
    else
    begin
      event_o = act & ~q.prev;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

endmodule : fpg_pin_cell

// ==== src/fpg_top.sv ====
`timescale 1ns/10ps
`include "fpg_defines.svh"
// Overview of operation
// - Sixteen flag pins, each individually input or output.
// - Lower eight pins are always general-purpose, never reassigned.
// - Upper eight pins are general-purpose on 8-bit bus unless owned for SPI select, data lines on 16-bit.
// - Twelve memory-mapped registers control the flag pins.
// - Direction register picks input or output per pin.
// - Output pins drive their bit of the flag value state.
// - Input pins are captured into the flag value state for software.
// - Value state changed by write-one-to-set and write-one-to-clear registers.
// - Each pin has its own interrupt enable.
// - Enables changed by write-one-to-enable and write-one-to-disable registers.
// - Enabled inputs are hardware sources, enabled outputs software sources.
// - Enabled requests latch into the pending latch; the core mask qualifies the interrupt output.
// - Polarity register chooses high or low as active per pin.
// - Sensitivity register picks level or edge; edge register picks edge kind.
// - Edge pins react to the edge into the active level only or to both edges.
// - Some upper pins serve as SPI select inputs and outputs when SPI is on with an 8-bit bus.
// - Some pins act as clock multiplier straps.
// - Software can force or clear pending flag interrupts.
module fpg_top
  import fpg_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire fpg_ahb_req_type  ahb_req_i,
  output fpg_ahb_rsp_type       ahb_rsp_o,
  input  wire logic [15:0]      flag_pins_i,
  output fpg_pin_drive_type     flag_pins_o,
  input  wire logic [7:0]       upper_external_data_lines_i,
  input  wire logic             upper_external_data_lines_oe_i,
  output logic [7:0]            upper_external_data_lines_o,
  input  wire logic [15:0]      spi_own_i,
  input  wire logic [15:0]      spi_sel_level_i,
  input  wire logic [15:0]      spi_sel_drive_i,
  output logic [15:0]           spi_sel_sense_o,
  output logic [15:0]           pending_interrupt_latch_o,
  output logic                  flag_irq_o,
  output logic [6:0]            mult_strap_o
);

  typedef struct packed {
    logic [15:0]     dir;
    logic [15:0]     val;
    logic [15:0]     ien;
    logic [15:0]     pol;
    logic [15:0]     sens;
    logic [15:0]     both;
    logic [15:0]     pend;
    logic [15:0]     cmask;
    logic [1:0]      cfg;
    logic            dph_wr;
    logic [5:0]      dph_idx;
    logic            dph_ok;
    fpg_ahb_rsp_type rsp;
    fpg_pin_drive_type pins;
    logic [7:0]      ext;
    logic [15:0]     spi;
    logic [6:0]      strap;
    logic            strap_wait;
    logic            irq;
  } fpg_state_type;

  fpg_state_type q;
  fpg_state_type d;
  logic [15:0]   lvl;
  logic [15:0]   evt;
  logic [15:0]   gp_mask;
  logic [15:0]   spi_mask;
  logic          take;

  // In 16-bit bus mode the upper pins belong to the data bus entirely.
  assign gp_mask = q.cfg[`FPG_CFG_BUS16] ? `FPG_LOWER_MASK : 16'hFFFF;
  // Select duty is confined to the upper pins so the lower byte stays general-purpose.
  assign spi_mask = q.cfg[`FPG_CFG_SPI] ? (spi_own_i & `FPG_UPPER_MASK & gp_mask)
                                        : 16'h0000;
  assign take = ahb_req_i.hsel & ahb_req_i.htrans[1] & ahb_req_i.hready;

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_cell
      fpg_pin_cell u_cell (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .pin_i    (flag_pins_i[gi]),
        .sw_val_i (q.val[gi]),
        .dir_i    (q.dir[gi]),
        .gp_i     (gp_mask[gi] & ~spi_mask[gi]),
        .pol_i    (q.pol[gi]),
        .sens_i   (q.sens[gi]),
        .both_i   (q.both[gi]),
        .level_o  (lvl[gi]),
        .event_o  (evt[gi])
      );
    end
  endgenerate

  function automatic logic [15:0] rd_word(input fpg_state_type s, input logic [5:0] idx);
    logic [15:0] r;
    r = 16'h0000;
    unique case (idx)
      `FPG_IDX_DIR:      r = s.dir;
      `FPG_IDX_VAL_SET:  r = s.val;
      `FPG_IDX_VAL_CLR:  r = s.val;
      `FPG_IDX_IEN_SET:  r = s.ien;
      `FPG_IDX_IEN_CLR:  r = s.ien;
      `FPG_IDX_POL:      r = s.pol;
      `FPG_IDX_SENS:     r = s.sens;
      `FPG_IDX_EDGE:     r = s.both;
      `FPG_IDX_PEND:     r = s.pend;
      `FPG_IDX_PEND_SET: r = s.pend;
      `FPG_IDX_CMASK:    r = s.cmask;
      `FPG_IDX_CFG:      r = {14'h0000, s.cfg};
      default:           r = 16'h0000;
    endcase
    return r;
  endfunction : rd_word

  always_comb
  begin
    logic [15:0] wd;
    logic [15:0] pclr;
    logic [15:0] pset;
    logic [15:0] lvl_drv;
    logic [15:0] oe_drv;
    d = q;
    wd = ahb_req_i.hwdata[15:0];
    pclr = 16'h0000;
    pset = 16'h0000;
    lvl_drv = 16'h0000;
    oe_drv = 16'h0000;

    // Writes land in the data phase; unmapped or out-of-range words are dropped.
    if (q.dph_wr && q.dph_ok)
    begin
      unique case (q.dph_idx)
        `FPG_IDX_DIR:      d.dir = wd;
        `FPG_IDX_VAL_SET:  d.val = q.val | wd;
        `FPG_IDX_VAL_CLR:  d.val = q.val & ~wd;
        `FPG_IDX_IEN_SET:  d.ien = q.ien | wd;
        `FPG_IDX_IEN_CLR:  d.ien = q.ien & ~wd;
        `FPG_IDX_POL:      d.pol = wd;
        `FPG_IDX_SENS:     d.sens = wd;
        `FPG_IDX_EDGE:     d.both = wd;
        `FPG_IDX_PEND:     pclr = wd;
        `FPG_IDX_PEND_SET: pset = wd;
        `FPG_IDX_CMASK:    d.cmask = wd;
        `FPG_IDX_CFG:      d.cfg = wd[1:0];
        default:           d.cmask = q.cmask;
      endcase
    end

    // Input bits follow the pin; software set/clear only sticks on outputs.
    d.val = (d.val & d.dir) | (lvl & ~d.dir);

    // Clears go first so that an event in the same cycle still lands.
    d.pend = (q.pend & ~pclr) | pset | (evt & q.ien);
    d.irq = |(d.pend & d.cmask);

    // Zero-wait slave; read data built from the next state to see a write
    // still in its data phase.
    d.dph_wr = take & ahb_req_i.hwrite;
    d.dph_idx = ahb_req_i.haddr[7:2];
    d.dph_ok = (ahb_req_i.haddr[31:8] == 24'h000000) && (ahb_req_i.haddr[7:2] <= `FPG_IDX_CFG);
    d.rsp.hreadyout = 1'b1;
    d.rsp.hresp = 1'b0;
    if (take && !ahb_req_i.hwrite)
    begin
      d.rsp.hrdata = d.dph_ok ? {16'h0000, rd_word(d, d.dph_idx)} : 32'h0000_0000;
    end

    // Pin drivers: data bus, then SPI select, then the flag value.
    lvl_drv = (spi_mask & spi_sel_level_i) | (~spi_mask & d.val);
    oe_drv = (spi_mask & spi_sel_drive_i) | (~spi_mask & d.dir);
    if (d.cfg[`FPG_CFG_BUS16])
    begin
      lvl_drv[15:8] = upper_external_data_lines_i;
      oe_drv[15:8] = {8{upper_external_data_lines_oe_i}};
    end
    d.pins.level = lvl_drv;
    d.pins.oe_n = ~oe_drv;
    d.ext = lvl[15:8];
    d.spi = lvl & spi_mask;

    // Straps are caught once, at the first edge after reset is released.
    if (q.strap_wait)
    begin
      d.strap = flag_pins_i[`FPG_STRAP_MSB:`FPG_STRAP_LSB];
      d.strap_wait = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
      q.rsp.hreadyout <= 1'b1;
      q.pins.oe_n <= 16'hFFFF;
      q.cfg <= `FPG_RST_CFG;
      q.strap_wait <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign ahb_rsp_o = q.rsp;
  assign flag_pins_o = q.pins;
  assign upper_external_data_lines_o = q.ext;
  assign spi_sel_sense_o = q.spi;
  assign pending_interrupt_latch_o = q.pend;
  assign flag_irq_o = q.irq;
  assign mult_strap_o = q.strap;

endmodule : fpg_top

// ==== tb/fpg_pin_model.sv ====
`timescale 1ns/10ps
module fpg_pin_model
  import fpg_pkg::*;
(
  input  wire logic [15:0]       ext_i,
  input  wire fpg_pin_drive_type drive_i,
  output logic [15:0]            pins_o
);
  // A pin the device drives shows its level; any other shows the outside source.
  assign pins_o = (drive_i.oe_n & ext_i) | (~drive_i.oe_n & drive_i.level);
endmodule : fpg_pin_model

// ==== tb/fpg_top_asserts.sv ====
`timescale 1ns/10ps
module fpg_top_asserts
  import fpg_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire fpg_ahb_req_type   ahb_req_i,
  input wire fpg_ahb_rsp_type   ahb_rsp_o,
  input wire logic [15:0]       flag_pins_i,
  input wire fpg_pin_drive_type flag_pins_o,
  input wire logic [7:0]        upper_external_data_lines_o,
  input wire logic [15:0]       pending_interrupt_latch_o,
  input wire logic              flag_irq_o,
  input wire logic [6:0]        mult_strap_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic take;
  assign take = ahb_req_i.hsel && ahb_req_i.htrans[1] && ahb_req_i.hready;
  bus_ready_a: assert property (ahb_rsp_o.hreadyout)
    else $error("hreadyout low");
  bus_okay_a: assert property (!ahb_rsp_o.hresp)
    else $error("error response");
  read_hold_a: assert property (
    !(take && !ahb_req_i.hwrite) |=> $stable(ahb_rsp_o.hrdata))
    else $error("read data moved");
  rst_pend_a: assert property (
    $fell(rst_i) |-> pending_interrupt_latch_o == 16'h0000)
    else $error("pending not cleared");
  rst_oe_a: assert property ($fell(rst_i) |-> flag_pins_o.oe_n == 16'hFFFF)
    else $error("pins driven after reset");
  strap_cap_a: assert property (
    $fell(rst_i) |=> mult_strap_o == $past(flag_pins_i[6:0]))
    else $error("strap mismatch");
  // Three edges: two synchroniser stages, then the output register.
  sync_lat_a: assert property (
    !rst_i[*4] |-> upper_external_data_lines_o == $past(flag_pins_i[15:8], 3))
    else $error("sync latency");
  irq_cause_a: assert property (
    flag_irq_o |-> (pending_interrupt_latch_o | $past(pending_interrupt_latch_o)) != 16'h0000)
    else $error("irq without pending");
  pend_fall_a: assert property (
    (!$past(rst_i) && ($past(pending_interrupt_latch_o) & ~pending_interrupt_latch_o) != 16'h0000)
    |-> $past(take && ahb_req_i.hwrite, 2))
    else $error("pending lost");
endmodule : fpg_top_asserts

bind fpg_top fpg_top_asserts u_fpg_top_asserts (.*);

// ==== tb/tb_fpg_top.sv ====
`timescale 1ns/10ps
module tb_fpg_top
  import fpg_pkg::*;
;
  logic              clk_i;
  logic              rst_i;
  fpg_ahb_req_type   q;
  fpg_ahb_rsp_type   r;
  fpg_pin_drive_type drv;
  logic [15:0]       ext;
  logic [15:0]       pins;
  logic [7:0]        ud;
  logic              uoe;
  logic [6:0]        strap;
  logic              irq;
  logic [7:0]        ud_o;
  logic [15:0]       own;
  logic [15:0]       slvl;
  logic [15:0]       sdrv;
  logic [15:0]       sense;
  logic [15:0]       pend;
  int                errors;
  int                samples_checked;

  fpg_top u_fpg_top (.clk_i(clk_i), .rst_i(rst_i), .ahb_req_i(q), .ahb_rsp_o(r),
    .flag_pins_i(pins), .flag_pins_o(drv), .upper_external_data_lines_i(ud),
    .upper_external_data_lines_oe_i(uoe), .upper_external_data_lines_o(ud_o),
    .spi_own_i(own), .spi_sel_level_i(slvl), .spi_sel_drive_i(sdrv),
    .spi_sel_sense_o(sense), .pending_interrupt_latch_o(pend), .flag_irq_o(irq),
    .mult_strap_o(strap));
  fpg_pin_model u_fpg_pin_model (.ext_i(ext), .drive_i(drv), .pins_o(pins));

  always @* q.hready = r.hreadyout;

  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  initial
  begin
    repeat (4000) @(posedge clk_i);
    errors++;
    end_of_test();
  end

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  // Reads compare against d; the slave's hready is waited for, never assumed.
  task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d);
    q.hsel   <= 1'b1;
    q.haddr  <= {24'h000000, a, 2'h0};
    q.htrans <= 2'h2;
    q.hwrite <= w;
    q.hsize  <= 3'h2;
    @(posedge clk_i);
    while (r.hreadyout !== 1'b1)
      @(posedge clk_i);
    q.hsel   <= 1'b0;
    q.htrans <= 2'h0;
    q.hwdata <= d;
    @(posedge clk_i);
    while (r.hreadyout !== 1'b1)
      @(posedge clk_i);
    if (!w)
    begin
      chk("hrdata", d, r.hrdata);
      chk("hresp", 32'h0, {31'h0, r.hresp});
    end
  endtask : xfer

  task automatic step(input logic v, input logic [31:0] e);
    ext[8] <= v;
    repeat (6) @(posedge clk_i);
    xfer(1'b0, 6'h08, e);
    chk("irq", {31'h0, e[8]}, {31'h0, irq});
    xfer(1'b1, 6'h08, 32'h0100);
  endtask : step

  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  initial
  begin
    errors = 0;
    samples_checked = 0;
    rst_i = 1'b1;
    q = '0;
    ext = 16'h3C00;
    ud = 8'h00;
    uoe = 1'b0;
    own = 16'h0000;
    slvl = 16'h0000;
    sdrv = 16'h0000;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    // Input bits of the value state already follow the pins after reset.
    for (int i = 0; i < 12; i++)
      xfer(1'b0, 6'(i), (i == 1 || i == 2) ? 32'h3C00 : 32'h0);
    xfer(1'b0, 6'h20, 32'h0);
    $display("test reset done");
    xfer(1'b1, 6'h00, 32'h00FF);
    xfer(1'b1, 6'h01, 32'hFFA5);
    xfer(1'b1, 6'h02, 32'h0021);
    repeat (4) @(posedge clk_i);
    xfer(1'b0, 6'h02, 32'h3C84);
    chk("oe_n", 32'hFF00, {16'h0, drv.oe_n});
    chk("level", 32'h84, {24'h0, drv.level[7:0]});
    $display("test gpio done");
    xfer(1'b1, 6'h05, 32'h0101);
    xfer(1'b1, 6'h06, 32'h0100);
    xfer(1'b1, 6'h03, 32'h0100);
    xfer(1'b1, 6'h0A, 32'h0100);
    step(1'b1, 32'h0100);
    step(1'b0, 32'h0000);
    xfer(1'b1, 6'h07, 32'h0100);
    step(1'b1, 32'h0100);
    step(1'b0, 32'h0100);
    xfer(1'b1, 6'h03, 32'h0200);
    repeat (4) @(posedge clk_i);
    xfer(1'b0, 6'h08, 32'h0200);
    xfer(1'b1, 6'h04, 32'h0200);
    xfer(1'b1, 6'h08, 32'h0200);
    xfer(1'b0, 6'h08, 32'h0000);
    xfer(1'b0, 6'h03, 32'h0100);
    xfer(1'b1, 6'h03, 32'h0001);
    xfer(1'b1, 6'h01, 32'h0001);
    xfer(1'b1, 6'h09, 32'h0020);
    repeat (4) @(posedge clk_i);
    xfer(1'b0, 6'h08, 32'h0021);
    chk("irq", 32'h0, {31'h0, irq});
    chk("pend", 32'h0021, {16'h0, pend});
    $display("test interrupt done");
    uoe <= 1'b1;
    ud  <= 8'h5A;
    xfer(1'b1, 6'h0B, 32'h0001);
    repeat (2) @(posedge clk_i);
    chk("oe_n", 32'h0, {16'h0, drv.oe_n});
    chk("level", 32'h5A85, {16'h0, drv.level});
    repeat (2) @(posedge clk_i);
    chk("ext_o", 32'h5A, {24'h0, ud_o});
    $display("test bus width done");
    // Pin 8 is a select output driven high, pin 9 a select input.
    own  <= 16'h0300;
    sdrv <= 16'h0100;
    slvl <= 16'h0100;
    ext  <= 16'h3E00;
    xfer(1'b1, 6'h0B, 32'h0002);
    repeat (5) @(posedge clk_i);
    chk("sense", 32'h0300, {16'h0, sense});
    chk("oe_n", 32'hFE00, {16'h0, drv.oe_n});
    chk("level", 32'h3D85, {16'h0, drv.level});
    chk("pend", 32'h0021, {16'h0, pend});
    $display("test select done");
    rst_i <= 1'b1;
    ext   <= 16'h3C55;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk("strap", 32'h55, {25'h0, strap});
    xfer(1'b0, 6'h01, 32'h3C55);
    $display("test strap done");
    end_of_test();
  end
endmodule : tb_fpg_top
